/* rtl/startup_supervisor.sv */
// Start-up timeout supervision, fault response and turn-off delay
// Behaviour
// - Time from end of turn-on delay until sense reaches 85% of target and fault past the limit.
// - Undervoltage detection is armed only after the soft-start rise ends.
// - The timeout limit covers 0 to 127 ms in 0.5 ms steps.
// - A zero timeout limit disables timeout detection.
// - A write to the timeout limit is an invalid command, flagged and alerted.
// - A timeout fault sets other-fault, output summary and timeout bits and alerts.
// - Bits 7:6 choose ignore, delayed shutdown, immediate shutdown, or invalid.
// - Bits 5:3 choose latch-off, one to six retries, or endless retries.
// - Bits 2:0 set the shutdown delay in ms and the hiccup as rise multiples.
// - Undefined response codes are refused as invalid data and alerted.
// - A stop condition waits the turn-off delay before energy delivery ends.
// - The turn-off delay covers 0 to 127.5 ms in 0.5 ms steps.
// - Out-of-range turn-off delay writes are refused, flagged and alerted.
// - Internal latency added to the turn-off delay stays below 50 us.
// - Rise time is 0 to 31.75 ms in 0.25 ms steps and, floored at 0.5 ms, is the hiccup base.
`timescale 1ns/1ps
module startup_supervisor
  import startup_supervisor_pkg::*;
#(
  parameter int          P_QMS_CYC   = QMS_CYC,
  parameter logic [10:0] P_LIMIT_MAN = LIMIT_MAN_RESET
) (
  // Core clock and reset
  input  wire logic     i_clk,
  input  wire logic     i_reset_n,
  // Command link, on the link clock
  input  wire logic     i_link_clk,
  input  wire logic     i_cmd_valid,
  input  wire cmd_req_t i_cmd,
  output logic          o_cmd_ready,
  output logic          o_rsp_valid,
  output cmd_rsp_t      o_rsp,
  // Converter sequencing and telemetry
  input  wire logic        i_enable,
  input  wire logic        i_ton_delay_done,
  input  wire logic        i_rise_done,
  input  wire logic [6:0]  i_rise_time,
  input  wire logic [15:0] i_vout_sense,
  input  wire logic [15:0] i_vout_target,
  // Power control and status
  output logic          o_run,
  output logic          o_uv_armed,
  output status_t       o_status,
  output logic          o_alert
);
  localparam int PW = $clog2(P_QMS_CYC + 1);

  // Link domain state
  cmd_req_t req_reg, req_next;
  cmd_rsp_t lrsp_reg, lrsp_next;
  logic req_tgl_reg, req_tgl_next;
  logic busy_reg, busy_next;
  logic lrspv_reg, lrspv_next;
  logic ack_s1_reg, ack_s2_reg, ack_s3_reg;

  // Core domain state
  logic rq_s1_reg, rq_s2_reg, rq_s3_reg;
  logic [7:0]  resp_reg, resp_next;
  logic [15:0] toff_reg, toff_next;
  status_t     status_reg, status_next;
  cmd_rsp_t    crsp_reg, crsp_next;
  logic        ack_tgl_reg, ack_tgl_next;
  state_t      state_reg, state_next;
  logic [11:0] timer_reg, timer_next;
  logic [PW-1:0] pre_reg, pre_next;
  logic [2:0]  retry_reg, retry_next;
  logic        run_reg, run_next;
  logic        uvarm_reg, uvarm_next;

  // Link side: take a request while idle, present the answer for one cycle
  always_comb begin
    req_next     = req_reg;
    req_tgl_next = req_tgl_reg;
    busy_next    = busy_reg;
    lrsp_next    = lrsp_reg;
    lrspv_next   = 1'b0;
    if (i_cmd_valid && !busy_reg) begin
      req_next     = i_cmd;
      req_tgl_next = !req_tgl_reg;
      busy_next    = 1'b1;
    end
    if (ack_s2_reg != ack_s3_reg) begin
      lrsp_next  = crsp_reg;   // Held stable by the core until next request
      lrspv_next = 1'b1;
      busy_next  = 1'b0;
    end
  end

  // Link side registers and acknowledge synchroniser
  always_ff @(posedge i_link_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      req_reg     <= '0;
      req_tgl_reg <= 1'b0;
      busy_reg    <= 1'b0;
      lrsp_reg    <= '0;
      lrspv_reg   <= 1'b0;
      ack_s1_reg  <= 1'b0;
      ack_s2_reg  <= 1'b0;
      ack_s3_reg  <= 1'b0;
    end else begin
      req_reg     <= req_next;
      req_tgl_reg <= req_tgl_next;
      busy_reg    <= busy_next;
      lrsp_reg    <= lrsp_next;
      lrspv_reg   <= lrspv_next;
      ack_s1_reg  <= ack_tgl_reg;
      ack_s2_reg  <= ack_s1_reg;
      ack_s3_reg  <= ack_s2_reg;
    end
  end

  assign o_cmd_ready = !busy_reg;
  assign o_rsp_valid = lrspv_reg;
  assign o_rsp       = lrsp_reg;

  // Derived values for the supervisor
  logic        fire, tick, reached, fault_evt, give_up, cmd_err, clear;
  logic [20:0] sense_sc, tgt_sc;
  logic [11:0] limit_ticks, toff_ticks, wait_ticks, hic_ticks;
  logic [2:0]  wait_ms, mult;
  logic [6:0]  rise_q;
  logic [15:0] limit_word;
  logic [1:0]  act;
  logic [2:0]  rty_cfg, dly_cfg;

  assign fire        = rq_s2_reg != rq_s3_reg;
  assign tick        = pre_reg == PW'(P_QMS_CYC - 1);
  assign act         = resp_reg[ACT_HI:ACT_LO];
  assign rty_cfg     = resp_reg[RTY_HI:RTY_LO];
  assign dly_cfg     = resp_reg[WAIT_HI:WAIT_LO];
  assign limit_word  = {EXP_HALF_MS, P_LIMIT_MAN};
  assign sense_sc    = 21'(i_vout_sense) * 21'(SENSE_NUM);
  assign tgt_sc      = 21'(i_vout_target) * 21'(TARGET_NUM);
  assign reached     = sense_sc >= tgt_sc;
  assign limit_ticks = {P_LIMIT_MAN, 1'b0};
  assign toff_ticks  = {toff_reg[MAN_HI:0], 1'b0};
  assign wait_ms     = (dly_cfg == 3'h0) ? 3'h1 : dly_cfg;
  assign wait_ticks  = 12'(wait_ms * 3'(TICKS_PER_MS));
  assign mult        = (dly_cfg < 3'h2) ? dly_cfg + 3'h1 : dly_cfg;
  assign rise_q      = (i_rise_time < RISE_MIN_QMS) ? RISE_MIN_QMS
                                                    : i_rise_time;
  assign hic_ticks   = 12'(mult * rise_q);
  assign fault_evt   = state_reg == ST_RAMP && i_enable && !reached
                    && P_LIMIT_MAN != 11'h0
                    && timer_reg > limit_ticks;
  assign give_up     = rty_cfg == RETRY_LATCH
                    || (rty_cfg != RETRY_ENDLESS && retry_reg >= rty_cfg);

  // Start-up, fault response and stop sequencing
  always_comb begin
    state_next = state_reg;
    retry_next = retry_reg;
    case (state_reg)
      ST_OFF: begin
        retry_next = 3'h0;
        if (i_enable) state_next = ST_RAMP;
      end
      ST_RAMP: begin
        if (!i_enable) state_next = ST_OFFDLY;
        else if (reached) state_next = ST_ON;
        else if (fault_evt) begin
          if (act == ACT_IGNORE) state_next = ST_ON;
          else if (act == ACT_DELAYED) state_next = ST_WAIT;
          else state_next = give_up ? ST_LATCH : ST_HICCUP;
        end
      end
      ST_ON: begin
        retry_next = 3'h0;
        if (!i_enable) state_next = ST_OFFDLY;
      end
      ST_WAIT: begin
        if (!i_enable) state_next = ST_OFFDLY;
        else if (reached) state_next = ST_ON;
        else if (timer_reg >= wait_ticks)
          state_next = give_up ? ST_LATCH : ST_HICCUP;
      end
      ST_HICCUP: begin
        if (!i_enable) state_next = ST_OFF;
        else if (timer_reg >= hic_ticks) begin
          state_next = ST_RAMP;
          if (retry_reg != RETRY_ENDLESS) retry_next = retry_reg + 3'h1;
        end
      end
      ST_LATCH: begin
        if (!i_enable) state_next = ST_OFF;
      end
      ST_OFFDLY: begin
        if (timer_reg >= toff_ticks) state_next = ST_OFF;
      end
      default: state_next = ST_OFF;
    endcase
  end

  // Tick prescaler and state timer restart on every state change
  always_comb begin
    pre_next   = (state_next != state_reg || tick) ? '0 : pre_reg + 1'b1;
    timer_next = timer_reg;
    if (state_next != state_reg) timer_next = 12'h0;
    else if (tick && timer_reg != 12'hfff
             && (state_reg != ST_RAMP || i_ton_delay_done))
      timer_next = timer_reg + 12'h1;
    run_next   = state_next == ST_RAMP || state_next == ST_ON
              || state_next == ST_WAIT || state_next == ST_OFFDLY;
    uvarm_next = run_next && i_rise_done;
  end

  // Command execution and status flags
  always_comb begin
    resp_next    = resp_reg;
    toff_next    = toff_reg;
    crsp_next    = crsp_reg;
    ack_tgl_next = ack_tgl_reg;
    cmd_err      = 1'b0;
    clear        = 1'b0;
    if (fire) begin
      ack_tgl_next = !ack_tgl_reg;
      crsp_next    = '0;
      if (req_reg.write) begin
        case (req_reg.code)
          CMD_LIMIT: cmd_err = 1'b1;
          CMD_RESP: begin
            if (req_reg.data[ACT_HI:ACT_LO] == ACT_BAD)
              cmd_err = 1'b1;
            else resp_next = req_reg.data[7:0];
          end
          CMD_OFFWAIT: begin
            if (req_reg.data[EXP_HI:EXP_LO] != EXP_HALF_MS
                || req_reg.data[MAN_HI:0] > OFFWAIT_MAN_MAX)
              cmd_err = 1'b1;
            else toff_next = req_reg.data;
          end
          CMD_CLEAR: clear = 1'b1;
          default: cmd_err = 1'b1;
        endcase
      end else begin
        case (req_reg.code)
          CMD_LIMIT:   crsp_next.data = limit_word;
          CMD_RESP:    crsp_next.data = {8'h00, resp_reg};
          CMD_OFFWAIT: crsp_next.data = toff_reg;
          default:     cmd_err = 1'b1;
        endcase
      end
      crsp_next.error = cmd_err;
    end
    // A new event in the clearing cycle survives
    status_next = clear ? '0 : status_reg;
    if (fault_evt) begin
      status_next.other_fault  = 1'b1;
      status_next.vout_summary = 1'b1;
      status_next.vout_timeout = 1'b1;
    end
    if (cmd_err) status_next.cml = 1'b1;
  end

  // Core registers and request synchroniser
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rq_s1_reg   <= 1'b0;
      rq_s2_reg   <= 1'b0;
      rq_s3_reg   <= 1'b0;
      resp_reg    <= RESP_RESET;
      toff_reg    <= OFFWAIT_RESET;
      status_reg  <= '0;
      crsp_reg    <= '0;
      ack_tgl_reg <= 1'b0;
      state_reg   <= ST_OFF;
      timer_reg   <= 12'h0;
      pre_reg     <= '0;
      retry_reg   <= 3'h0;
      run_reg     <= 1'b0;
      uvarm_reg   <= 1'b0;
    end else begin
      rq_s1_reg   <= req_tgl_reg;
      rq_s2_reg   <= rq_s1_reg;
      rq_s3_reg   <= rq_s2_reg;
      resp_reg    <= resp_next;
      toff_reg    <= toff_next;
      status_reg  <= status_next;
      crsp_reg    <= crsp_next;
      ack_tgl_reg <= ack_tgl_next;
      state_reg   <= state_next;
      timer_reg   <= timer_next;
      pre_reg     <= pre_next;
      retry_reg   <= retry_next;
      run_reg     <= run_next;
      uvarm_reg   <= uvarm_next;
    end
  end

  assign o_run      = run_reg;
  assign o_uv_armed = uvarm_reg;
  assign o_status   = status_reg;
  assign o_alert    = |status_reg;

  // Checks on the core domain
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  sequence s_stop_on;
    state_reg == ST_ON && !i_enable && toff_reg[MAN_HI:0] == 11'h0;
  endsequence
  sequence s_quick_off;
    state_reg == ST_OFFDLY ##1 state_reg == ST_OFF && !o_run;
  endsequence

  a_fault_flags: assert property (fault_evt |=>
    o_status.other_fault && o_status.vout_summary
    && o_status.vout_timeout && o_alert)
    else $error("timeout fault flags not set");
  a_zero_limit: assert property (P_LIMIT_MAN == 11'h0
    |-> !fault_evt) else $error("fault with zero limit");
  a_fault_late: assert property (fault_evt
    |-> timer_reg > limit_ticks && !reached)
    else $error("fault before limit expired");
  a_ignore_run: assert property (fault_evt && act == ACT_IGNORE
    |=> state_reg == ST_ON && o_run) else $error("ignore stopped");
  a_now_stop: assert property (fault_evt && act[1]
    |=> !o_run) else $error("immediate shutdown missed");
  a_latch_zero: assert property (fault_evt && act[1]
    && rty_cfg == RETRY_LATCH |=> state_reg == ST_LATCH)
    else $error("latch-off missed");
  a_bad_resp: assert property (fire && req_reg.write
    && req_reg.code == CMD_RESP && req_reg.data[7:6] == ACT_BAD
    |=> $stable(resp_reg) && o_status.cml)
    else $error("bad response code accepted");
  a_bad_offwait: assert property (fire && req_reg.write
    && req_reg.code == CMD_OFFWAIT
    && req_reg.data[EXP_HI:EXP_LO] != EXP_HALF_MS
    |=> $stable(toff_reg) && o_status.cml)
    else $error("bad turn-off delay accepted");
  a_limit_wr: assert property (fire && req_reg.write
    && req_reg.code == CMD_LIMIT |=> o_status.cml && crsp_reg.error)
    else $error("limit write not refused");
  a_zero_off: assert property (s_stop_on |=> s_quick_off)
    else $error("zero turn-off delay not honoured");
  a_uv_arm: assert property (o_uv_armed |-> $past(i_rise_done))
    else $error("undervoltage armed before rise end");
  a_retry_clr: assert property (state_reg == ST_ON
    |=> retry_reg == 3'h0) else $error("retry count kept");
endmodule

/* rtl/startup_supervisor_pkg.sv */
// Constants, field layouts and carrier types of the start-up supervisor
package startup_supervisor_pkg;
  // Timing base: every timer runs in quarter-millisecond ticks
  localparam int CLK_PERIOD_NS = 5;
  localparam int QMS_US        = 250;
  localparam int QMS_CYC       = QMS_US * 1000 / CLK_PERIOD_NS;
  localparam int TICKS_PER_MS  = 4;
  // Command codes
  localparam logic [7:0] CMD_CLEAR   = 8'h03;
  localparam logic [7:0] CMD_LIMIT   = 8'h62;
  localparam logic [7:0] CMD_RESP    = 8'h63;
  localparam logic [7:0] CMD_OFFWAIT = 8'h64;
  // Field positions of the response byte and of linear words
  localparam int ACT_HI  = 7;
  localparam int ACT_LO  = 6;
  localparam int RTY_HI  = 5;
  localparam int RTY_LO  = 3;
  localparam int WAIT_HI = 2;
  localparam int WAIT_LO = 0;
  localparam int EXP_HI  = 15;
  localparam int EXP_LO  = 11;
  localparam int MAN_HI  = 10;
  // Field codes
  localparam logic [4:0] EXP_HALF_MS   = 5'h1f;
  localparam logic [1:0] ACT_IGNORE    = 2'h0;
  localparam logic [1:0] ACT_DELAYED   = 2'h1;
  localparam logic [1:0] ACT_BAD       = 2'h3;
  localparam logic [2:0] RETRY_LATCH   = 3'h0;
  localparam logic [2:0] RETRY_ENDLESS = 3'h7;
  localparam logic [10:0] LIMIT_MAN_MAX   = 11'h0fe;
  localparam logic [10:0] OFFWAIT_MAN_MAX = 11'h0ff;
  localparam logic [6:0]  RISE_MIN_QMS    = 7'h02;
  // Reset values of the programmable words
  localparam logic [10:0] LIMIT_MAN_RESET = 11'h014;
  localparam logic [7:0]  RESP_RESET      = 8'h80;
  localparam logic [15:0] OFFWAIT_RESET   = 16'hf800;
  // 85 percent threshold as sense * 20 >= target * 17
  localparam logic [4:0] SENSE_NUM  = 5'h14;
  localparam logic [4:0] TARGET_NUM = 5'h11;

  typedef enum logic [2:0] {
    ST_OFF    = 3'b000,
    ST_RAMP   = 3'b001,
    ST_ON     = 3'b011,
    ST_OFFDLY = 3'b010,
    ST_WAIT   = 3'b110,
    ST_HICCUP = 3'b111,
    ST_LATCH  = 3'b101
  } state_t;

  typedef struct packed {
    logic        write;
    logic [7:0]  code;
    logic [15:0] data;
  } cmd_req_t;

  typedef struct packed {
    logic        error;
    logic [15:0] data;
  } cmd_rsp_t;

  typedef struct packed {
    logic other_fault;
    logic vout_summary;
    logic vout_timeout;
    logic cml;
  } status_t;
endpackage

/* testbench/link_host.sv */
// Host controller model driving the command link
`timescale 1ns/1ps
module link_host
  import startup_supervisor_pkg::*;
(
  // Link clock and answer from the supervisor
  input  wire logic     i_link_clk,
  input  wire logic     i_cmd_ready,
  input  wire logic     i_rsp_valid,
  input  wire cmd_rsp_t i_rsp,
  // Request towards the supervisor
  output logic          o_cmd_valid,
  output cmd_req_t      o_cmd
);
  // Idle link at time zero
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd = '0;
  end

  // One request held until taken, then the answer is collected
  task automatic transfer(input logic wr, input logic [7:0] c,
                          input logic [15:0] d, output cmd_rsp_t rsp,
                          output logic ok);
    int   n;
    logic tk;
    n = 0;
    tk = 1'b0;
    ok = 1'b0;
    rsp = '0;
    @(posedge i_link_clk);
    #1;
    o_cmd_valid = 1'b1;
    o_cmd = '{wr, c, d}; // Bench bytes pass unchanged
    // Ready seen between edges is the level sampled at the coming edge
    while (!tk && n < 20) begin
      tk = (i_cmd_ready === 1'b1);
      @(posedge i_link_clk);
      n++;
    end
    #1;
    o_cmd_valid = 1'b0;
    o_cmd = ~o_cmd; // Released lines never show a stale request
    n = 0;
    // The answer stands one link cycle, so look just after each edge
    while (tk && !ok && n < 20) begin
      @(posedge i_link_clk);
      #1;
      if (i_rsp_valid === 1'b1) begin
        ok = 1'b1;
        rsp = i_rsp;
      end
      n++;
    end
  endtask
endmodule

/* testbench/tb_startup_supervisor.sv */
// Self-checking bench of the start-up supervisor
`timescale 1ns/1ps
module tb_startup_supervisor;
  import startup_supervisor_pkg::*;
  localparam int          QC = 4;
  localparam logic [10:0] LM = 11'h003;
  logic        i_clk = 1'b0, i_link_clk = 1'b0, i_reset_n = 1'b0;
  logic        i_cmd_valid, o_cmd_ready, o_rsp_valid;
  cmd_req_t    i_cmd;
  cmd_rsp_t    o_rsp, rsp;
  logic        i_enable = 1'b0, i_ton_delay_done = 1'b0;
  logic        i_rise_done = 1'b0, ok, prv, bad;
  logic [6:0]  i_rise_time = 7'h02;
  logic [15:0] i_vout_sense = 16'h0, i_vout_target = 16'h1000;
  logic [15:0] d, off_m = OFFWAIT_RESET;
  logic [7:0]  b, resp_m = RESP_RESET;
  logic [10:0] m;
  logic [31:0] lfsr = 32'he5aa;
  logic        o_run, o_uv_armed, o_alert;
  status_t     o_status;
  int          fails = 0, checked = 0, cyc = 0, n, k;

  startup_supervisor #(.P_QMS_CYC(QC), .P_LIMIT_MAN(LM)) startup_supervisor_i (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_link_clk(i_link_clk),
    .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .o_cmd_ready(o_cmd_ready),
    .o_rsp_valid(o_rsp_valid), .o_rsp(o_rsp), .i_enable(i_enable),
    .i_ton_delay_done(i_ton_delay_done), .i_rise_done(i_rise_done),
    .i_rise_time(i_rise_time), .i_vout_sense(i_vout_sense),
    .i_vout_target(i_vout_target), .o_run(o_run), .o_uv_armed(o_uv_armed),
    .o_status(o_status), .o_alert(o_alert));
  link_host link_host_i (
    .i_link_clk(i_link_clk), .i_cmd_ready(o_cmd_ready),
    .i_rsp_valid(o_rsp_valid), .i_rsp(o_rsp), .o_cmd_valid(i_cmd_valid),
    .o_cmd(i_cmd));

  // Core clock, and a link clock of unrelated phase
  always #2.5 i_clk = ~i_clk;
  initial begin
    #7;
    forever #24 i_link_clk = ~i_link_clk;
  end

  // Cut a hang short
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      test_done;
    end
  end

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic off_bad(input logic [15:0] w);
    return w[EXP_HI:EXP_LO] != EXP_HALF_MS || w[MAN_HI:0] > OFFWAIT_MAN_MAX;
  endfunction
  function automatic int off_cyc(input logic [10:0] w);
    return 2 * int'(w) * QC;
  endfunction

  task automatic test_done;
    if (fails == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [16:0] e,
                     input logic [16:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic xfer(input logic wr, input logic [7:0] c,
                      input logic [15:0] w);
    link_host_i.transfer(wr, c, w, rsp, ok);
    chk("link answer", 17'h1, 17'(ok));
  endtask
  task automatic cyc_wait(input int c);
    repeat (c) @(posedge i_clk);
    #1;
  endtask
  task automatic flag_wait;
    n = 0;
    while (o_status.vout_timeout !== 1'b1 && n < 400) begin
      cyc_wait(1);
      n++;
    end
  endtask
  // Count converter starts while enabled, then stop and clear
  task automatic episode(input logic [7:0] r, input int c);
    xfer(1'b1, CMD_RESP, {8'h00, r});
    i_enable = 1'b1;
    prv = 1'b0;
    k = 0;
    repeat (c) begin
      cyc_wait(1);
      if (o_run === 1'b1 && !prv) k++;
      prv = o_run;
    end
    i_enable = 1'b0;
    cyc_wait(5);
    xfer(1'b1, CMD_CLEAR, 16'h0);
  endtask

  // Main sequence
  initial begin
    repeat (2) @(posedge i_link_clk);
    #1 i_reset_n = 1'b1;
    xfer(1'b0, CMD_RESP, 16'h0);
    chk("resp reset", {9'h0, RESP_RESET}, rsp);
    xfer(1'b0, CMD_LIMIT, 16'h0);
    chk("limit read", {1'b0, EXP_HALF_MS, LM}, rsp);
    xfer(1'b0, 8'h10, 16'h0);
    chk("unknown read", 17'h10000, rsp);
    xfer(1'b1, CMD_LIMIT, 16'hf802);
    chk("limit write", 17'h1, 17'(rsp.error));
    chk("cml flag", 17'h1, 17'(o_status));
    chk("alert", 17'h1, 17'(o_alert));
    xfer(1'b1, CMD_RESP, 16'h00c0);
    chk("resp bad", 17'h1, 17'(rsp.error));
    // Random writes of the delay word and the response byte
    for (int i = 0; i < 8; i++) begin
      lfsr = next_rand(lfsr);
      d = lfsr[0] ? {EXP_HALF_MS, 2'h0, lfsr[16:8]} : lfsr[15:0];
      bad = off_bad(d);
      xfer(1'b1, CMD_OFFWAIT, d);
      chk("offwait err", 17'(bad), 17'(rsp.error));
      if (!bad) off_m = d;
      xfer(1'b0, CMD_OFFWAIT, 16'h0);
      chk("offwait read", {1'b0, off_m}, rsp);
      b = lfsr[24:17];
      xfer(1'b1, CMD_RESP, {8'h00, b});
      chk("resp err", 17'(b[ACT_HI:ACT_LO] == ACT_BAD), 17'(rsp.error));
      if (b[ACT_HI:ACT_LO] != ACT_BAD) resp_m = b;
      xfer(1'b0, CMD_RESP, 16'h0);
      chk("resp read", {9'h0, resp_m}, rsp);
    end
    xfer(1'b1, CMD_CLEAR, 16'h0);
    chk("clear", 17'h0, 17'(o_status));
    // Good start-ups just above 85 percent, then turn-off delays
    xfer(1'b1, CMD_RESP, 16'h0080);
    i_vout_sense = 16'h0d9a;
    i_ton_delay_done = 1'b1;
    for (int i = 0; i < 3; i++) begin
      lfsr = next_rand(lfsr);
      m = (i == 0) ? 11'h0 : (i == 1) ? 11'h2 : {8'h0, lfsr[2:0]} + 11'h1;
      xfer(1'b1, CMD_OFFWAIT, {EXP_HALF_MS, m});
      i_rise_done = 1'b0;
      i_enable = 1'b1;
      cyc_wait(60);
      chk("run up", 17'h1, 17'(o_run));
      chk("no fault", 17'h0, 17'(o_status));
      chk("uv early", 17'h0, 17'(o_uv_armed));
      i_rise_done = 1'b1;
      cyc_wait(2);
      chk("uv armed", 17'h1, 17'(o_uv_armed));
      i_enable = 1'b0;
      n = 0;
      while (o_run === 1'b1 && n < 2000) begin
        cyc_wait(1);
        n++;
      end
      chk("off wait", 17'h1, 17'(n >= off_cyc(m) - QC
          && n <= off_cyc(m) + QC + 3));
    end
    // Just below 85 percent: immediate shutdown, latched off
    i_vout_sense = 16'h0d99;
    i_enable = 1'b1;
    flag_wait;
    chk("limit time", 17'h1, 17'(n >= 2 * LM * QC - QC
        && n <= (2 * LM + 2) * QC + 4));
    cyc_wait(2);
    chk("fault bits", 17'he, 17'(o_status));
    chk("fault alert", 17'h1, 17'(o_alert));
    cyc_wait(100);
    chk("latched", 17'h0, 17'(o_run));
    i_enable = 1'b0;
    cyc_wait(5);
    xfer(1'b1, CMD_CLEAR, 16'h0);
    // Ignore keeps running; delayed shutdown waits 1 ms
    episode(8'h00, 120);
    chk("ignore", 17'h1, 17'(k));
    xfer(1'b1, CMD_RESP, 16'h0041);
    i_enable = 1'b1;
    flag_wait;
    n = 0;
    while (o_run === 1'b1 && n < 400) begin
      cyc_wait(1);
      n++;
    end
    chk("delay 1ms", 17'h1, 17'(n >= TICKS_PER_MS * QC - QC
        && n <= TICKS_PER_MS * QC + QC + 3));
    i_enable = 1'b0;
    cyc_wait(5);
    xfer(1'b1, CMD_CLEAR, 16'h0);
    // Two retries, twice over, then endless retries
    repeat (2) begin
      episode(8'h90, 600);
      chk("retries", 17'h3, 17'(k));
    end
    episode(8'hb8, 600);
    chk("endless", 17'h1, 17'(k >= 8));
    test_done;
  end
endmodule
